//--- logic/exp_defines.svh
// Offsets, reset values and timing counts of the I/O expander
`ifndef EXP_DEFINES_SVH
`define EXP_DEFINES_SVH

// Register offsets, selected by the command byte
`define EXP_IN0      8'h00
`define EXP_IN1      8'h01
`define EXP_OUT0     8'h02
`define EXP_OUT1     8'h03
`define EXP_POL0     8'h04
`define EXP_POL1     8'h05
`define EXP_DIR0     8'h06
`define EXP_DIR1     8'h07
`define EXP_DRV0     8'h40
`define EXP_DRV1     8'h41
`define EXP_DRV2     8'h42
`define EXP_DRV3     8'h43
`define EXP_LAT0     8'h44
`define EXP_LAT1     8'h45
`define EXP_PEN0     8'h46
`define EXP_PEN1     8'h47
`define EXP_PSEL0    8'h48
`define EXP_PSEL1    8'h49
`define EXP_MSK0     8'h4a
`define EXP_MSK1     8'h4b
`define EXP_STAT0    8'h4c
`define EXP_STAT1    8'h4d
`define EXP_OCFG     8'h4f

// Reset values
`define EXP_RST_DIR  16'hffff
`define EXP_RST_OUT  16'hffff
`define EXP_RST_POL  16'h0000
`define EXP_RST_DRV  32'hffff_ffff
`define EXP_RST_LAT  16'h0000
`define EXP_RST_PEN  16'h0000
`define EXP_RST_PSEL 16'hffff
`define EXP_RST_MSK  16'hffff
`define EXP_RST_OCFG 2'h0

// Slave address: upper six bits fixed, lowest bit from the strap
`define EXP_ADDR_BASE 6'h10

// Timing
`define EXP_CLK_NS   25
`define EXP_SPIKE_NS 50
`define EXP_SPIKE_CYC ((`EXP_SPIKE_NS + `EXP_CLK_NS - 1) / `EXP_CLK_NS)

`endif

//--- logic/exp_pkg.sv
// Types shared by the I/O expander modules
package exp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100
  } exp_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } exp_line_s;

  typedef struct packed {
    logic dir_in;
    logic out_val;
    logic od;
  } exp_pin_ctl_s;

endpackage : exp_pkg

//--- logic/exp_filt.sv
// Synchroniser and spike filter for the serial clock and data lines
`timescale 1ns/1ps
`include "exp_defines.svh"
module exp_filt #(
  parameter int CYC = `EXP_SPIKE_CYC
) (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst,
  // Raw and filtered lines
  input  wire logic           scl_raw,
  input  wire logic           sda_raw,
  output exp_pkg::exp_line_s  clean
);

  logic [1:0] raw;
  logic [1:0] outv;

  assign raw   = {scl_raw, sda_raw};
  assign clean = exp_pkg::exp_line_s'(outv);

  for (genvar b = 0; b < 2; b++) begin : g_line
    logic       s1;
    logic       s2;
    logic [3:0] cnt;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        s1 <= 1'b1;
        s2 <= 1'b1;
      end else begin
        s1 <= raw[b];
        s2 <= s1;
      end
    end

    // Level must hold CYC cycles before it passes, so short spikes die here
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        cnt     <= 4'h0;
        outv[b] <= 1'b1;
      end else if (s2 == outv[b]) begin
        cnt <= 4'h0;
      end else if (cnt >= 4'(CYC - 1)) begin
        cnt     <= 4'h0;
        outv[b] <= s2;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

endmodule : exp_filt

//--- logic/exp_pin.sv
// One port pin: output stage and input synchroniser
`timescale 1ns/1ps
module exp_pin (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Control
  input  wire exp_pkg::exp_pin_ctl_s ctl,
  // Pad
  input  wire logic                 pad_i,
  output logic                      pad_o,
  output logic                      pad_oe,
  // Synchronised level
  output logic                      lvl
);

  logic s1;

  // Reset keeps the pad released, so nothing toggles during power-up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_o  <= 1'b0;
      pad_oe <= 1'b0;
    end else if (ctl.dir_in) begin
      pad_o  <= 1'b0;
      pad_oe <= 1'b0;
    end else if (ctl.od) begin
      pad_o  <= 1'b0;
      pad_oe <= ~ctl.out_val;
    end else begin
      pad_o  <= ctl.out_val;
      pad_oe <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1  <= 1'b0;
      lvl <= 1'b0;
    end else begin
      s1  <= pad_i;
      lvl <= s1;
    end
  end

endmodule : exp_pin

//--- logic/exp_top.sv
// Sixteen-pin I/O expander behind a two-wire serial slave
// How it works
// - All sixteen pins are inputs after reset
// - Every interrupt mask bit resets to masked
// - Direction bit decides drive or release per pin
// - Direction, input, output, polarity as byte pairs
// - Polarity bit inverts the reported input level
// - Reset pin low equals full power-on reset
// - Alert pulled low on unmasked input change
// - Latched inputs hold changes until input read
// - Masked pins never raise the alert
// - Read-only status shows which pins alerted
// - Per-bank push-pull or open-drain outputs
// - Four drive strength levels per pin
// - Per-pin pull enable and up/down select
// - Address strap picks one of two addresses
// - Output register held and driven until rewritten
// - Serial clock and data are spike filtered
// - No pin glitches while power-up runs
`timescale 1ns/1ps
`include "exp_defines.svh"
module exp_top #(
  parameter logic [5:0] ADDR_BASE = `EXP_ADDR_BASE
) (
  // Clock and power-on reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Reset and address strap pins
  input  wire logic        reset_n,
  input  wire logic        addr_strap,
  // Serial bus
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Alert, open drain, active low
  output logic             alert_n_o,
  output logic             alert_n_oe,
  // Port pins
  input  wire logic [15:0] gpio_i,
  output logic      [15:0] gpio_o,
  output logic      [15:0] gpio_oe,
  // Pad settings
  output logic      [31:0] drive_str,
  output logic      [15:0] pull_en,
  output logic      [15:0] pull_up
);

  ////////////////////////////////////////////////////////////////////////
  // Reset and strap

  logic       rstn_s1;
  logic       rstn_s2;
  logic       ireset;
  logic       adr_s1;
  logic       adr_s2;
  logic       addr_lsb;
  logic [1:0] prime_cnt;
  logic       primed;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rstn_s1 <= 1'b0;
      rstn_s2 <= 1'b0;
      adr_s1  <= 1'b0;
      adr_s2  <= 1'b0;
    end else begin
      rstn_s1 <= reset_n;
      rstn_s2 <= rstn_s1;
      adr_s1  <= addr_strap;
      adr_s2  <= adr_s1;
    end
  end

  // Pin reset takes the same path as power-on
  assign ireset = rst | ~rstn_s2;
  assign primed = (prime_cnt == 2'h3);

  // Waits for the synchronisers to fill before trusting pin levels
  always_ff @(posedge sys_clk) begin
    if (ireset) begin
      prime_cnt <= 2'h0;
    end else if (!primed) begin
      prime_cnt <= prime_cnt + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ireset) begin
      addr_lsb <= 1'b0;
    end else if (prime_cnt == 2'h2) begin
      addr_lsb <= adr_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus line filtering and events

  exp_pkg::exp_line_s line;
  logic               scl_d;
  logic               sda_d;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_ev;
  logic               stop_ev;

  exp_filt u_filt (
    .sys_clk (sys_clk),
    .rst     (ireset),
    .scl_raw (scl_i),
    .sda_raw (sda_i),
    .clean   (line)
  );

  always_ff @(posedge sys_clk) begin
    if (ireset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= line.scl;
      sda_d <= line.sda;
    end
  end

  assign scl_rise = line.scl & ~scl_d;
  assign scl_fall = ~line.scl & scl_d;
  assign start_ev = line.scl & scl_d & sda_d & ~line.sda;
  assign stop_ev  = line.scl & scl_d & ~sda_d & line.sda;

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [15:0] dir_in;
  logic [15:0] out_reg;
  logic [15:0] pol;
  logic [15:0] lat_en;
  logic [15:0] msk;
  logic [1:0]  ocfg;
  logic [15:0] int_stat;
  logic [15:0] in_val;
  logic [7:0]  ptr;
  logic [7:0]  shreg;
  logic        wr_stb;

  // Defaults: inputs, masked, pull-up selected, strongest drive
  always_ff @(posedge sys_clk) begin
    if (ireset) begin
      dir_in    <= `EXP_RST_DIR;
      out_reg   <= `EXP_RST_OUT;
      pol       <= `EXP_RST_POL;
      drive_str <= `EXP_RST_DRV;
      lat_en    <= `EXP_RST_LAT;
      pull_en   <= `EXP_RST_PEN;
      pull_up   <= `EXP_RST_PSEL;
      msk       <= `EXP_RST_MSK;
      ocfg      <= `EXP_RST_OCFG;
    end else if (wr_stb) begin
      case (ptr)
        `EXP_OUT0:  out_reg[7:0]     <= shreg;
        `EXP_OUT1:  out_reg[15:8]    <= shreg;
        `EXP_POL0:  pol[7:0]         <= shreg;
        `EXP_POL1:  pol[15:8]        <= shreg;
        `EXP_DIR0:  dir_in[7:0]      <= shreg;
        `EXP_DIR1:  dir_in[15:8]     <= shreg;
        `EXP_DRV0:  drive_str[7:0]   <= shreg;
        `EXP_DRV1:  drive_str[15:8]  <= shreg;
        `EXP_DRV2:  drive_str[23:16] <= shreg;
        `EXP_DRV3:  drive_str[31:24] <= shreg;
        `EXP_LAT0:  lat_en[7:0]      <= shreg;
        `EXP_LAT1:  lat_en[15:8]     <= shreg;
        `EXP_PEN0:  pull_en[7:0]     <= shreg;
        `EXP_PEN1:  pull_en[15:8]    <= shreg;
        `EXP_PSEL0: pull_up[7:0]     <= shreg;
        `EXP_PSEL1: pull_up[15:8]    <= shreg;
        `EXP_MSK0:  msk[7:0]         <= shreg;
        `EXP_MSK1:  msk[15:8]        <= shreg;
        `EXP_OCFG:  ocfg             <= shreg[1:0];
        // Input and status are read-only; unknown offsets are dropped
        default: ;
      endcase
    end
  end

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `EXP_IN0:   r = in_val[7:0];
      `EXP_IN1:   r = in_val[15:8];
      `EXP_OUT0:  r = out_reg[7:0];
      `EXP_OUT1:  r = out_reg[15:8];
      `EXP_POL0:  r = pol[7:0];
      `EXP_POL1:  r = pol[15:8];
      `EXP_DIR0:  r = dir_in[7:0];
      `EXP_DIR1:  r = dir_in[15:8];
      `EXP_DRV0:  r = drive_str[7:0];
      `EXP_DRV1:  r = drive_str[15:8];
      `EXP_DRV2:  r = drive_str[23:16];
      `EXP_DRV3:  r = drive_str[31:24];
      `EXP_LAT0:  r = lat_en[7:0];
      `EXP_LAT1:  r = lat_en[15:8];
      `EXP_PEN0:  r = pull_en[7:0];
      `EXP_PEN1:  r = pull_en[15:8];
      `EXP_PSEL0: r = pull_up[7:0];
      `EXP_PSEL1: r = pull_up[15:8];
      `EXP_MSK0:  r = msk[7:0];
      `EXP_MSK1:  r = msk[15:8];
      `EXP_STAT0: r = int_stat[7:0];
      `EXP_STAT1: r = int_stat[15:8];
      `EXP_OCFG:  r = {6'h00, ocfg};
      default:    r = 8'h00;
    endcase
    return r;
  endfunction : rd_byte

  // Byte pairs wrap within the pair, drive strength within its four
  function automatic logic [7:0] nxt_ptr(input logic [7:0] a);
    logic [7:0] n;
    n = {a[7:1], ~a[0]};
    if (a[7:2] == 6'h10) begin
      n = {a[7:2], a[1:0] + 2'h1};
    end
    return n;
  endfunction : nxt_ptr

  ////////////////////////////////////////////////////////////////////////
  // Port pins

  logic [15:0] lvl;

  for (genvar i = 0; i < 16; i++) begin : g_pin
    exp_pkg::exp_pin_ctl_s ctl;
    assign ctl.dir_in  = dir_in[i];
    assign ctl.out_val = out_reg[i];
    assign ctl.od      = ocfg[i / 8];

    exp_pin u_pin (
      .sys_clk (sys_clk),
      .rst     (ireset),
      .ctl     (ctl),
      .pad_i   (gpio_i[i]),
      .pad_o   (gpio_o[i]),
      .pad_oe  (gpio_oe[i]),
      .lvl     (lvl[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Input capture, latching and change detection

  logic [1:0]  rd_clr;
  logic [15:0] change;
  logic [15:0] next_stat;

  for (genvar i = 0; i < 16; i++) begin : g_chg
    logic live;
    logic snap;
    logic hold;
    logic lval;

    assign live      = lvl[i] ^ pol[i];
    assign in_val[i] = hold ? lval : live;
    assign change[i] = dir_in[i] & (lat_en[i] ? hold : (live != snap));

    // Snapshot takes the value just read, so a change racing the read is kept
    always_ff @(posedge sys_clk) begin
      if (ireset) begin
        snap <= 1'b0;
        hold <= 1'b0;
        lval <= 1'b0;
      end else if (!primed) begin
        snap <= live;
      end else if (rd_clr[i / 8]) begin
        snap <= in_val[i];
        hold <= 1'b0;
      end else if (lat_en[i] && !hold && live != snap) begin
        hold <= 1'b1;
        lval <= live;
      end
    end
  end

  assign next_stat = change & ~msk;

  always_ff @(posedge sys_clk) begin
    if (ireset) begin
      int_stat   <= 16'h0000;
      alert_n_o  <= 1'b0;
      alert_n_oe <= 1'b0;
    end else begin
      int_stat   <= next_stat;
      alert_n_o  <= 1'b0;
      alert_n_oe <= |next_stat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial slave state machine

  exp_pkg::exp_state_e st;
  logic [3:0]          bitcnt;
  logic                mack;
  logic [6:0]          my_addr;
  logic [7:0]          rd_now;

  assign my_addr = {ADDR_BASE, addr_lsb};
  always_comb rd_now = rd_byte(ptr);

  // Start and stop override everything; bus engine resets with the rest
  always_ff @(posedge sys_clk) begin
    if (ireset) begin
      st     <= exp_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shreg  <= 8'h00;
      ptr    <= 8'h00;
      mack   <= 1'b0;
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      rd_clr <= 2'b00;
    end else begin
      wr_stb <= 1'b0;
      rd_clr <= 2'b00;
      sda_o  <= 1'b0;
      if (wr_stb) begin
        ptr <= nxt_ptr(ptr);
      end
      if (start_ev) begin
        st     <= exp_pkg::ST_ADDR;
        bitcnt <= 4'hf; // Start's own clock fall wraps this to zero
        sda_oe <= 1'b0;
      end else if (stop_ev) begin
        st     <= exp_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (st != exp_pkg::ST_IDLE && scl_rise) begin
        if (bitcnt == 4'h8) begin
          mack <= ~line.sda;
        end else if (st != exp_pkg::ST_RD) begin
          shreg <= {shreg[6:0], line.sda};
        end
      end else if (st != exp_pkg::ST_IDLE && scl_fall) begin
        if (bitcnt == 4'h7) begin
          bitcnt <= 4'h8;
          unique case (st)
            exp_pkg::ST_ADDR: begin
              if (shreg[7:1] == my_addr) begin
                sda_oe <= 1'b1;
                mack   <= 1'b1;
                st     <= shreg[0] ? exp_pkg::ST_RD : exp_pkg::ST_CMD;
              end else begin
                st <= exp_pkg::ST_IDLE;
              end
            end
            exp_pkg::ST_CMD: begin
              ptr    <= shreg;
              sda_oe <= 1'b1;
              st     <= exp_pkg::ST_WR;
            end
            exp_pkg::ST_WR: begin
              wr_stb <= 1'b1;
              sda_oe <= 1'b1;
            end
            exp_pkg::ST_RD: begin
              ptr    <= nxt_ptr(ptr);
              sda_oe <= 1'b0;
            end
            exp_pkg::ST_IDLE: ;
          endcase
        end else if (bitcnt == 4'h8) begin
          bitcnt <= 4'h0;
          sda_oe <= 1'b0;
          if (st == exp_pkg::ST_RD) begin
            if (mack) begin
              shreg  <= rd_now;
              sda_oe <= ~rd_now[7];
              if (ptr == `EXP_IN0) begin
                rd_clr <= 2'b01;
              end
              if (ptr == `EXP_IN1) begin
                rd_clr <= 2'b10;
              end
            end else begin
              st <= exp_pkg::ST_IDLE;
            end
          end
        end else begin
          bitcnt <= bitcnt + 4'h1;
          if (st == exp_pkg::ST_RD) begin
            shreg  <= {shreg[6:0], 1'b0};
            sda_oe <= ~shreg[6];
          end
        end
      end
    end
  end

endmodule : exp_top

//--- test/exp_checker.sv
// Checker for the expander's pin, pad, alert and serial data outputs
`timescale 1ns/1ps
module exp_checker (
  // Clock and resets
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reset_n,
  // Strap and serial bus
  input wire logic        addr_strap,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // Alert
  input wire logic        alert_n_o,
  input wire logic        alert_n_oe,
  // Pins and pads
  input wire logic [15:0] gpio_i,
  input wire logic [15:0] gpio_o,
  input wire logic [15:0] gpio_oe,
  input wire logic [31:0] drive_str,
  input wire logic [15:0] pull_en,
  input wire logic [15:0] pull_up
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  scl_hi;
  logic [7:0]  quiet;
  logic [15:0] gpio_q;
  logic        bus_used;

  // Idle time and pin quiet time; register changes only follow bus or pin activity
  always_ff @(posedge sys_clk) begin
    scl_hi <= (rst || !scl_i) ? 8'h00 : (scl_hi == 8'hff ? scl_hi : scl_hi + 8'h01);
  end
  always_ff @(posedge sys_clk) begin
    gpio_q <= gpio_i;
    quiet  <= (rst || gpio_i != gpio_q) ? 8'h00 : (quiet == 8'hff ? quiet : quiet + 8'h01);
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !reset_n) begin
      bus_used <= 1'b0;
    end else if (!scl_i) begin
      bus_used <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !reset_n);

  property p_rst_dflt;
    disable iff (1'b0) rst |=> gpio_oe == 16'h0000 && !alert_n_oe && drive_str == 32'hffff_ffff
      && pull_en == 16'h0000 && pull_up == 16'hffff;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("outputs not at reset values");

  property p_pin_rst;
    disable iff (1'b0) !reset_n [*4] |=> gpio_oe == 16'h0000 && !alert_n_oe && pull_en == 16'h0000;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("reset pin did not restore outputs");

  property p_open_drain;
    !alert_n_o && !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain output driven high");

  property p_pins_idle;
    scl_hi >= 8'h10 |-> $stable(gpio_oe) && $stable(gpio_o) && $stable(drive_str) && $stable(pull_en)
      && $stable(pull_up);
  endproperty
  a_pins_idle: assert property (p_pins_idle) else $error("pin outputs moved on an idle bus");

  property p_inputs_first;
    !bus_used |-> gpio_oe == 16'h0000;
  endproperty
  a_inputs_first: assert property (p_inputs_first) else $error("pin driven before any write");

  property p_masked_first;
    !bus_used |-> !alert_n_oe;
  endproperty
  a_masked_first: assert property (p_masked_first) else $error("alert before any unmask");

  property p_alert_rise;
    $rose(alert_n_oe) |-> quiet < 8'h08 || scl_hi < 8'h10;
  endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("alert raised without cause");

  property p_alert_fall;
    $fell(alert_n_oe) |-> quiet < 8'h08 || scl_hi < 8'h10;
  endproperty
  a_alert_fall: assert property (p_alert_fall) else $error("alert released without cause");
endmodule : exp_checker

bind exp_top exp_checker u_chk (.sys_clk, .rst, .reset_n, .addr_strap, .scl_i, .sda_i, .sda_o, .sda_oe,
  .alert_n_o, .alert_n_oe, .gpio_i, .gpio_o, .gpio_oe, .drive_str, .pull_en, .pull_up);

//--- test/exp_i2c_master.sv
// Two-wire bus master model for the expander's serial port
`timescale 1ns/1ps
module exp_i2c_master (
  // Clock
  input wire logic sys_clk,
  // Bus lines
  input wire logic sda_in,
  output logic     scl,
  output logic     sda_low
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Eight cycles a bit; long low phase so slave data settles before the filtered clock rises
  task automatic bit_io(input logic b, output logic r);
    @(posedge sys_clk) sda_low <= ~b;
    tick(4);
    @(posedge sys_clk) scl <= 1'b1;
    tick(1);
    #1 r = sda_in;
    @(posedge sys_clk) scl <= 1'b0;
  endtask : bit_io

  // Also serves as repeated start
  task automatic bus_start;
    @(posedge sys_clk) sda_low <= 1'b0;
    tick(6);
    @(posedge sys_clk) scl <= 1'b1;
    tick(3);
    @(posedge sys_clk) sda_low <= 1'b1;
    tick(3);
    @(posedge sys_clk) scl <= 1'b0;
  endtask : bus_start

  task automatic bus_stop;
    @(posedge sys_clk) sda_low <= 1'b1;
    tick(6);
    @(posedge sys_clk) scl <= 1'b1;
    tick(3);
    @(posedge sys_clk) sda_low <= 1'b0;
    tick(8);
  endtask : bus_stop

  // Eight bits then the acknowledge slot; nak is the line level in that slot
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, nak);
  endtask : xfer
endmodule : exp_i2c_master

//--- test/tb_top.sv
// Self-checking bench for the expander through its serial port and pins
`timescale 1ns/1ps
`include "exp_defines.svh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst, reset_n, addr_strap, scl, sda_low, sda_o, sda_oe, alert_n_o, alert_n_oe, nak;
  logic [15:0] ext, gpio_o, gpio_oe, pull_en, pull_up;
  logic [31:0] drive_str;
  logic [7:0]  rd;
  int          errors = 0;
  int          cmp_count = 0;
  wire logic        sda_wire = ~(sda_low | sda_oe);
  wire logic [15:0] gpio_pin = (gpio_oe & gpio_o) | (~gpio_oe & ext);

  always #12.5 sys_clk = ~sys_clk;

  exp_top dut (.sys_clk, .rst, .reset_n, .addr_strap, .scl_i (scl), .sda_i (sda_wire), .sda_o, .sda_oe,
    .alert_n_o, .alert_n_oe, .gpio_i (gpio_pin), .gpio_o, .gpio_oe, .drive_str, .pull_en, .pull_up);
  exp_i2c_master bfm (.sys_clk, .sda_in (sda_wire), .scl, .sda_low);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  function automatic logic [7:0] dev(input logic rd_bit);
    return {`EXP_ADDR_BASE, addr_strap, rd_bit};
  endfunction : dev

  task automatic open_dev(input logic [7:0] off);
    logic [7:0] rx;
    logic       nk;
    bfm.bus_start();
    bfm.xfer(dev(1'b0), 1'b1, rx, nk);
    check(nk, 1'b0);
    bfm.xfer(off, 1'b1, rx, nk);
  endtask : open_dev

  task automatic reg_wr(input logic [7:0] off, input logic [31:0] d, input int n);
    logic [7:0] rx;
    logic       nk;
    open_dev(off);
    for (int i = 0; i < n; i++) bfm.xfer(d[8*i +: 8], 1'b1, rx, nk);
    bfm.bus_stop();
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] off, output logic [7:0] v);
    logic [7:0] rx;
    logic       nk;
    open_dev(off);
    bfm.bus_start();
    bfm.xfer(dev(1'b1), 1'b1, rx, nk);
    bfm.xfer(8'hff, 1'b1, v, nk);
    bfm.bus_stop();
  endtask : reg_rd

  // Bounded wait; running out counts a mismatch and ends the run
  task automatic wait_alert(input logic lvl);
    int k = 0;
    while (alert_n_oe !== lvl && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    check(alert_n_oe, lvl);
    if (k == 200) complete_run();
  endtask : wait_alert

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reset_n = 1'b1;
    addr_strap = 1'b0;
    ext = 16'h0000;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (16) @(posedge sys_clk);
    check(gpio_oe, 16'h0000);
    check(drive_str, 32'hffff_ffff);
    check({pull_en, pull_up}, 32'h0000_ffff);
    @(posedge sys_clk) ext <= 16'h0100;
    repeat (20) @(posedge sys_clk);
    check(alert_n_oe, 1'b0);
    bfm.bus_start();
    bfm.xfer(dev(1'b0) ^ 8'h02, 1'b1, rd, nak);
    bfm.bus_stop();
    check(nak, 1'b1);
    $display("test reset_and_address done");
    reg_wr(`EXP_OUT0, 32'h0000_a55a, 2);
    reg_wr(`EXP_DIR0, 32'h0000_0f00, 2);
    check(gpio_oe, 16'hf0ff);
    check(gpio_o & gpio_oe, 16'ha05a);
    reg_rd(`EXP_DIR1, rd);
    check(rd, 8'h0f);
    reg_wr(`EXP_POL1, 32'h0000_0003, 1);
    reg_rd(`EXP_IN1, rd);
    check(rd, 8'ha2);
    reg_wr(`EXP_OCFG, 32'h0000_0001, 1);
    check({gpio_oe, gpio_o[7:0]}, 24'hf0a5_00);
    $display("test direction_output_polarity done");
    reg_wr(`EXP_DRV2, 32'h1baa_5500, 4);
    check(drive_str, 32'h5500_1baa);
    reg_wr(`EXP_PEN0, 32'h0000_813c, 2);
    reg_wr(`EXP_PSEL0, 32'h0000_0ff0, 2);
    check({pull_en, pull_up}, 32'h813c_0ff0);
    $display("test pad_settings done");
    reg_wr(`EXP_MSK1, 32'h0000_00f0, 1);
    repeat (20) @(posedge sys_clk);
    check(alert_n_oe, 1'b0);
    @(posedge sys_clk) ext <= 16'h0300;
    wait_alert(1'b1);
    reg_rd(`EXP_STAT1, rd);
    check(rd, 8'h02);
    @(posedge sys_clk) ext <= 16'h0100;
    wait_alert(1'b0);
    reg_wr(`EXP_LAT1, 32'h0000_0002, 1);
    @(posedge sys_clk) ext <= 16'h0300;
    wait_alert(1'b1);
    @(posedge sys_clk) ext <= 16'h0100;
    repeat (20) @(posedge sys_clk);
    check(alert_n_oe, 1'b1);
    reg_rd(`EXP_IN1, rd);
    check(rd, 8'ha0);
    wait_alert(1'b1);
    reg_rd(`EXP_IN1, rd);
    check(rd, 8'ha2);
    wait_alert(1'b0);
    $display("test alert_and_latch done");
    @(posedge sys_clk) reset_n <= 1'b0;
    addr_strap <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (16) @(posedge sys_clk);
    check({gpio_oe, pull_en}, 32'h0000_0000);
    check(drive_str, 32'hffff_ffff);
    reg_rd(`EXP_POL1, rd);
    check(rd, 8'h00);
    $display("test reset_pin done");
    complete_run();
  end
endmodule : tb_top
